// File: rtl/loop_pkg.sv
// Constants and types shared by the cellular test loop controller
package loop_pkg;
    // Controller state, one-hot: which loop or test mode is active
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SS = 6'h02,
        ST_MSG = 6'h04,
        ST_MSH = 6'h08,
        ST_PRBS = 6'h10,
        ST_LOOP = 6'h20
    } state_e;
    // Command codes from the layer-3 message decoder
    localparam logic [2:0] CMD_CLOSE_MS = 3'h1;
    localparam logic [2:0] CMD_OPEN_MS = 3'h2;
    localparam logic [2:0] CMD_CLOSE_SS = 3'h3;
    localparam logic [2:0] CMD_OPEN_SS = 3'h4;
    localparam logic [2:0] CMD_TEST_MODE = 3'h5;
    // Register byte offsets
    localparam logic [7:0] ADDR_CAP = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PDU = 8'h08;
    localparam logic [7:0] ADDR_FRAMES = 8'h0c;
    // Field positions in the capability and status registers
    localparam int CAP_PRBS_BIT = 0;
    localparam int CAP_LOOP_BIT = 1;
    localparam int CAP_EXT_BIT = 2;
    localparam int STATUS_TYPE_C_BIT = 8;
    // Reset values and the type C acknowledgement element
    localparam logic [2:0] CAP_RESET = 3'h3;
    localparam logic [14:0] PN_SEED = 15'h7fff;
    localparam logic [7:0] ACK_ELEM_TYPE_C = 8'h01;
    // Countdown value carried while countdown is disabled
    localparam logic [3:0] CV_LOOPBACK = 4'hf;
    // Longest delay from close acknowledgement to loop in place
    localparam logic [6:0] LOOP_SETUP_FRAMES = 7'd104;
endpackage

// File: rtl/test_loop_ctrl.sv
// Cellular test loop and packet test mode controller with Avalon-MM registers
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
module test_loop_ctrl
    import loop_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic cmd_erased,
    input wire logic cmd_type_c,
    input wire logic cmd_mode_sel,
    input wire logic [15:0] cmd_pdu_count,
    input wire logic [2:0] cmd_dl_offset,
    input wire logic tch_active,
    input wire logic call_disconnect,
    input wire logic frame_tick,
    input wire logic ec_operation,
    input wire logic dl_frm_valid,
    input wire logic [15:0] dl_frm_word,
    input wire logic dl_frm_bad,
    input wire logic dl_frm_facch,
    input wire logic dl_blk_valid,
    input wire logic dl_blk_ctrl,
    input wire logic [15:0] dl_blk_word,
    input wire logic [2:0] dl_blk_ts,
    input wire logic [7:0] dl_ts_mask,
    input wire logic dl_crc_ok,
    input wire logic dl_usf_ok,
    input wire logic ul_req,
    input wire logic [2:0] ul_ts,
    input wire logic ul_usf_grant,
    input wire logic ul_ctrl_pending,
    input wire logic tbf_release,
    input wire logic dl_release,
    input wire logic pdch_release,
    output logic ms_close_ack,
    output logic ms_open_ack,
    output logic ss_open_msg,
    output logic [7:0] ack_elem,
    output logic ul_frm_valid,
    output logic [15:0] ul_frm_word,
    output logic facch_fwd,
    output logic frm_to_codec,
    output logic llc_valid,
    output logic [15:0] llc_word,
    output logic ctrl_valid,
    output logic [15:0] ctrl_word,
    output logic ul_blk_valid,
    output logic [15:0] ul_blk_word,
    output logic [3:0] ul_cv,
    output logic [2:0] ul_blk_ts
);
    state_e state;
    logic [2:0] cap;
    logic ss_type_c;
    logic [15:0] pdu_left;
    logic [2:0] dl_off;
    logic [6:0] frames;
    logic [14:0] pn;
    logic [14:0] next_pn;
    logic [15:0] pn_word;
    logic [15:0] loop_mem [8];
    logic [2:0] dl_idx;
    logic [3:0] dl_count;
    logic [2:0] rd_idx;

    // Count of set bits, used for slot numbering
    function automatic logic [3:0] ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    // Command acceptance, decided from the state, the traffic channel and the capabilities
    wire cmd_ok = cmd_valid & ~call_disconnect;
    wire is_idle = (state == ST_IDLE);
    wire ms_closed = (state == ST_MSG) | (state == ST_MSH);
    wire test_on = (state == ST_PRBS) | (state == ST_LOOP);
    wire close_ms_ok = cmd_ok & (cmd_code == CMD_CLOSE_MS) & tch_active & is_idle;
    wire close_ss_ok = cmd_ok & (cmd_code == CMD_CLOSE_SS) & tch_active & is_idle;
    wire open_ss_ok = cmd_ok & (cmd_code == CMD_OPEN_SS) & (state == ST_SS);
    wire open_ms_ok = cmd_ok & (cmd_code == CMD_OPEN_MS) & ms_closed;
    // Loop-back is never offered in extended coverage
    wire use_loop = cap[CAP_LOOP_BIT] & ~ec_operation & (~cap[CAP_PRBS_BIT] | cmd_mode_sel);
    wire tm_ok = cmd_ok & (cmd_code == CMD_TEST_MODE) & is_idle
        & (cap[CAP_PRBS_BIT] | use_loop);
    wire prbs_end = (state == ST_PRBS) & (tbf_release | (pdu_left == 16'h0000));
    wire loop_end = (state == ST_LOOP) & (dl_release | pdch_release);
    // Extended coverage uses its fixed allocation, not the uplink flag
    wire grant = ec_operation ? 1'b1 : ul_usf_grant;
    wire ul_go = ul_req & grant & ~ul_ctrl_pending & test_on;

    // Single controller state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else if (call_disconnect) begin
            state <= ST_IDLE;
        end else if (prbs_end | loop_end) begin
            state <= ST_IDLE;
        end else if (close_ms_ok) begin
            state <= cmd_erased ? ST_MSH : ST_MSG;
        end else if (close_ss_ok) begin
            state <= ST_SS;
        end else if (open_ss_ok | open_ms_ok) begin
            state <= ST_IDLE;
        end else if (tm_ok) begin
            state <= use_loop ? ST_LOOP : ST_PRBS;
        end
    end

    // Command answers; disconnect never acknowledges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ms_close_ack <= 1'b0;
            ms_open_ack <= 1'b0;
            ss_open_msg <= 1'b0;
            ack_elem <= 8'h00;
        end else begin
            ms_close_ack <= close_ms_ok;
            ms_open_ack <= open_ms_ok;
            ss_open_msg <= open_ss_ok & ss_type_c;
            if (open_ss_ok & ss_type_c) begin
                ack_elem <= ACK_ELEM_TYPE_C;
            end
        end
    end

    // Loop type, test parameters and frames since loop closure
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ss_type_c <= 1'b0;
            pdu_left <= 16'h0000;
            dl_off <= 3'h0;
            frames <= 7'h00;
        end else begin
            if (close_ss_ok) begin
                ss_type_c <= cmd_type_c;
            end
            if (tm_ok) begin
                pdu_left <= cmd_pdu_count;
                dl_off <= cmd_dl_offset;
            end else if (ul_go & (state == ST_PRBS) & (pdu_left != 16'h0000)) begin
                pdu_left <= pdu_left - 16'h0001;
            end
            // Loop is in place at once, well inside the setup period
            if (close_ms_ok) begin
                frames <= 7'h00;
            end else if (frame_tick & ms_closed & (frames != 7'h7f)) begin
                frames <= frames + 7'h01;
            end
        end
    end

    // Speech and data frame loop; unlooped frames other than FACCH go to the codec
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ul_frm_valid <= 1'b0;
            ul_frm_word <= 16'h0000;
            facch_fwd <= 1'b0;
            frm_to_codec <= 1'b0;
        end else begin
            facch_fwd <= dl_frm_valid & dl_frm_facch;
            frm_to_codec <= dl_frm_valid & ~dl_frm_facch & ~ms_closed;
            ul_frm_valid <= 1'b0;
            if (dl_frm_valid & (state == ST_MSG)) begin
                ul_frm_valid <= 1'b1;
                ul_frm_word <= dl_frm_word;
            end else if (dl_frm_valid & (state == ST_MSH) & ~dl_frm_facch) begin
                ul_frm_valid <= 1'b1;
                ul_frm_word <= dl_frm_bad ? 16'h0000 : dl_frm_word;
            end
        end
    end

    // Downlink block routing; control blocks with a good CRC always handled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            llc_valid <= 1'b0;
            llc_word <= 16'h0000;
            ctrl_valid <= 1'b0;
            ctrl_word <= 16'h0000;
        end else begin
            llc_valid <= dl_blk_valid & ~dl_blk_ctrl & dl_crc_ok & ~test_on;
            llc_word <= dl_blk_word;
            ctrl_valid <= dl_blk_valid & dl_blk_ctrl & dl_crc_ok;
            ctrl_word <= dl_blk_word;
        end
    end

    // Downlink slot number from the commanded offset, wrapping 7 to 0
    always_comb begin
        logic [7:0] rot;
        logic [2:0] pos;
        logic [7:0] below;
        logic [3:0] cnt;
        rot = (dl_ts_mask >> dl_off) | (dl_ts_mask << (4'h8 - {1'b0, dl_off}));
        pos = dl_blk_ts - dl_off;
        below = (8'h01 << pos) - 8'h01;
        // At most seven slots lie below, so the count fits three bits
        cnt = ones(rot & below);
        dl_idx = cnt[2:0];
        dl_count = ones(dl_ts_mask);
    end

    // Uplink slot n reads downlink slot n, extra slots reuse the last
    always_comb begin
        if (~cap[CAP_EXT_BIT] | (dl_count <= 4'h1)) begin
            rd_idx = 3'h0;
        end else if ({1'b0, ul_ts} >= dl_count) begin
            rd_idx = dl_count[2:0] - 3'h1;
        end else begin
            rd_idx = ul_ts;
        end
    end

    // Received payload store; control blocks leave the old payload
    always_ff @(posedge clk) begin
        if ((state == ST_LOOP) & dl_blk_valid & ~dl_blk_ctrl & (dl_crc_ok | dl_usf_ok)) begin
            loop_mem[cap[CAP_EXT_BIT] ? dl_idx : 3'h0] <= dl_blk_word;
        end
    end

    // Sixteen steps of a 15-bit maximal generator per block
    always_comb begin
        logic [14:0] s;
        s = pn;
        pn_word = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            pn_word = {pn_word[14:0], s[14]};
            s = {s[13:0], s[14] ^ s[13]};
        end
        next_pn = s;
    end

    // Generator advances on each granted pseudorandom uplink request, even when no PDU is left to send
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pn <= PN_SEED;
        end else if (ul_go & (state == ST_PRBS)) begin
            pn <= next_pn;
        end
    end

    // Uplink data blocks for both test modes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ul_blk_valid <= 1'b0;
            ul_blk_word <= 16'h0000;
            ul_cv <= 4'h0;
            ul_blk_ts <= 3'h0;
        end else begin
            ul_blk_valid <= ul_go & ~(state == ST_PRBS & pdu_left == 16'h0000);
            ul_blk_ts <= ul_ts;
            if (state == ST_LOOP) begin
                ul_blk_word <= loop_mem[rd_idx];
                ul_cv <= CV_LOOPBACK;
            end else begin
                ul_blk_word <= pn_word;
                ul_cv <= (pdu_left > 16'h000f) ? 4'hf : pdu_left[3:0] - 4'h1;
            end
        end
    end

    // Avalon slave: one wait cycle, answer on the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
            cap <= CAP_RESET;
        end else begin
            waitrequest <= ~((read | write) & waitrequest);
            if (read & waitrequest) begin
                case (address)
                    ADDR_CAP: readdata <= {29'h0, cap};
                    ADDR_STATUS: readdata <= {23'h0, ss_type_c, 2'h0, state};
                    ADDR_PDU: readdata <= {16'h0, pdu_left};
                    ADDR_FRAMES: readdata <= {25'h0, frames};
                    default: readdata <= 32'h0000_0000;
                endcase
            end
            if (write & ~waitrequest & (address == ADDR_CAP)) begin
                cap <= writedata[2:0];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    close_ack_state_a: assert property (close_ms_ok |=> ms_close_ack && ms_closed
        && frames < LOOP_SETUP_FRAMES) else $error("close not acknowledged with loop");
    close_ignore_a: assert property (cmd_ok && cmd_code == CMD_CLOSE_MS && !is_idle
        |=> !ms_close_ack) else $error("close accepted while loop busy");
    good_frame_loop_a: assert property (state == ST_MSH && dl_frm_valid && !dl_frm_bad
        && !dl_frm_facch |=> ul_frm_valid && ul_frm_word == $past(dl_frm_word))
        else $error("good frame not looped");
    bad_frame_zero_a: assert property (state == ST_MSH && dl_frm_valid && dl_frm_bad
        && !dl_frm_facch |=> ul_frm_valid && ul_frm_word == 16'h0000)
        else $error("bad frame not zeroed");
    facch_pass_a: assert property (state == ST_MSH && dl_frm_valid && dl_frm_facch
        |=> facch_fwd && !ul_frm_valid) else $error("signalling frame looped");
    ss_open_idle_a: assert property (open_ss_ok |=> is_idle) else $error("ss loop stays");
    type_c_msg_a: assert property (ss_open_msg |-> ack_elem[0] && $past(state) == ST_SS)
        else $error("type C open message wrong");
    ms_open_ack_a: assert property (open_ms_ok |=> ms_open_ack && is_idle)
        else $error("multi-slot open not acknowledged");
    llc_block_a: assert property (test_on && $past(test_on) |-> !llc_valid)
        else $error("data reached link layer in test mode");
    loop_cv_a: assert property (ul_blk_valid && $past(state) == ST_LOOP |-> ul_cv == 4'hf)
        else $error("countdown not 15 in loop-back");
    ctrl_keep_a: assert property (dl_blk_valid && dl_blk_ctrl && dl_crc_ok |=> ctrl_valid)
        else $error("control block lost");
    disc_open_a: assert property (call_disconnect |=> is_idle && !ms_open_ack)
        else $error("disconnect left loop or acked");

    cover property (close_ms_ok ##[1:50] open_ms_ok);
    cover property (state == ST_PRBS ##1 is_idle);
    cover property (ul_blk_valid && state == ST_LOOP);
endmodule

// File: testbench/sim_station_model.sv
// Test equipment model: issues layer-3 test commands and paces air frames
`timescale 1ns/1ns
module sim_station_model
    import loop_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    output logic cmd_valid,
    output logic [2:0] cmd_code,
    output logic cmd_erased,
    output logic cmd_type_c,
    output logic cmd_mode_sel,
    output logic [15:0] cmd_pdu_count,
    output logic [2:0] cmd_dl_offset,
    output logic frame_tick
);
    logic test_busy;
    logic [2:0] tick_cnt = 3'h0;

    initial begin
        {cmd_valid, cmd_code, cmd_erased, cmd_type_c, cmd_mode_sel} = '0;
        {cmd_pdu_count, cmd_dl_offset, frame_tick, test_busy} = '0;
    end

    // Short frame period keeps frame counts quick in simulation
    always @(posedge clk) begin
        tick_cnt <= tick_cnt + 3'h1;
        frame_tick <= !rst && tick_cnt == 3'h7;
    end

    // One command pulse; a second test mode command is dropped until the first has ended
    task automatic send(input logic [2:0] code, input logic er, input logic tc,
                        input logic ms, input logic [15:0] pdu, input logic [2:0] off);
        if (code == CMD_TEST_MODE && test_busy) begin
            return;
        end
        test_busy = test_busy || code == CMD_TEST_MODE;
        @(posedge clk);
        cmd_valid <= 1'b1;
        {cmd_code, cmd_erased, cmd_type_c, cmd_mode_sel} <= {code, er, tc, ms};
        {cmd_pdu_count, cmd_dl_offset} <= {pdu, off};
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask

    // Called once the bench has seen the test mode end
    task automatic test_done;
        test_busy = 1'b0;
    endtask
endmodule

// File: testbench/test_cellular_test_loop_control.sv
// Self-checking bench for the cellular test loop controller
`timescale 1ns/1ns
module test_cellular_test_loop_control;
    import loop_pkg::*;
    typedef struct packed {
        logic tch;
        logic [2:0] code;
        logic erased;
        logic tc;
        logic [2:0] acks;
        logic [5:0] state;
    } row_s;
    logic clk, rst, read, write, waitrequest, tch_active, call_disconnect, ec_operation;
    logic [7:0] address, dl_ts_mask, ack_elem;
    logic [31:0] writedata, readdata, rd;
    logic dl_frm_valid, dl_frm_bad, dl_frm_facch, dl_blk_valid, dl_blk_ctrl, dl_crc_ok;
    logic dl_usf_ok, ul_req, ul_usf_grant, ul_ctrl_pending, tbf_release, dl_release;
    logic pdch_release, cmd_valid, cmd_erased, cmd_type_c, cmd_mode_sel, frame_tick;
    logic [15:0] dl_frm_word, dl_blk_word, cmd_pdu_count, ul_frm_word, llc_word;
    logic [15:0] ctrl_word, ul_blk_word;
    logic [2:0] dl_blk_ts, ul_ts, cmd_code, cmd_dl_offset, ul_blk_ts;
    logic ms_close_ack, ms_open_ack, ss_open_msg, ul_frm_valid, facch_fwd, frm_to_codec;
    logic llc_valid, ctrl_valid, ul_blk_valid;
    logic [3:0] ul_cv;
    int fail_count = 0;
    int checks_done = 0;
    // Command table: channel state, command, qualifiers, acks {close,open,single}, state
    row_s rows [10] = '{
        '{1'b0, 3'h1, 1'b1, 1'b0, 3'h0, 6'h01}, '{1'b1, 3'h1, 1'b1, 1'b0, 3'h4, 6'h08},
        '{1'b1, 3'h1, 1'b0, 1'b0, 3'h0, 6'h08}, '{1'b1, 3'h4, 1'b0, 1'b0, 3'h0, 6'h08},
        '{1'b1, 3'h2, 1'b0, 1'b0, 3'h2, 6'h01}, '{1'b1, 3'h2, 1'b0, 1'b0, 3'h0, 6'h01},
        '{1'b1, 3'h4, 1'b0, 1'b0, 3'h0, 6'h01}, '{1'b1, 3'h3, 1'b0, 1'b1, 3'h0, 6'h02},
        '{1'b1, 3'h1, 1'b0, 1'b0, 3'h0, 6'h02}, '{1'b1, 3'h4, 1'b0, 1'b0, 3'h1, 6'h01}};

    test_loop_ctrl test_loop_ctrl_inst (
        .clk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest,
        .cmd_valid, .cmd_code, .cmd_erased, .cmd_type_c, .cmd_mode_sel, .cmd_pdu_count,
        .cmd_dl_offset, .tch_active, .call_disconnect, .frame_tick, .ec_operation,
        .dl_frm_valid, .dl_frm_word, .dl_frm_bad, .dl_frm_facch, .dl_blk_valid,
        .dl_blk_ctrl, .dl_blk_word, .dl_blk_ts, .dl_ts_mask, .dl_crc_ok, .dl_usf_ok,
        .ul_req, .ul_ts, .ul_usf_grant, .ul_ctrl_pending, .tbf_release, .dl_release,
        .pdch_release, .ms_close_ack, .ms_open_ack, .ss_open_msg, .ack_elem,
        .ul_frm_valid, .ul_frm_word, .facch_fwd, .frm_to_codec, .llc_valid, .llc_word,
        .ctrl_valid, .ctrl_word, .ul_blk_valid, .ul_blk_word, .ul_cv, .ul_blk_ts);

    sim_station_model sim_station_model_inst (
        .clk, .rst, .cmd_valid, .cmd_code, .cmd_erased, .cmd_type_c, .cmd_mode_sel,
        .cmd_pdu_count, .cmd_dl_offset, .frame_tick);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Avalon transfer held until waitrequest is seen low; a hang counts as a mismatch
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        {read, write, address, writedata} <= {!wr, wr, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rd = readdata;
        {read, write} <= 2'b00;
        if (n >= 20) fail_count++;
    endtask

    task automatic status_is(input logic [5:0] s);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check(32'(rd[5:0]), 32'(s));
    endtask

    // Single-cycle pulse on a release line
    task automatic release_pulse(input int which);
        @(posedge clk);
        if (which == 0) begin
            call_disconnect <= 1'b1;
        end else begin
            pdch_release <= 1'b1;
        end
        @(posedge clk);
        {call_disconnect, pdch_release} <= 2'b00;
    endtask

    // Each stimulus task returns just after the edge that produces the answer
    task automatic frame(input logic [15:0] w, input logic bad, input logic fa);
        @(posedge clk);
        {dl_frm_valid, dl_frm_word, dl_frm_bad, dl_frm_facch} <= {1'b1, w, bad, fa};
        @(posedge clk);
        dl_frm_valid <= 1'b0;
        #1;
    endtask

    task automatic blk(input logic [15:0] w, input logic [2:0] ts, input logic c,
                       input logic crc, input logic usf);
        @(posedge clk);
        {dl_blk_valid, dl_blk_word, dl_blk_ts, dl_blk_ctrl} <= {1'b1, w, ts, c};
        {dl_crc_ok, dl_usf_ok} <= {crc, usf};
        @(posedge clk);
        dl_blk_valid <= 1'b0;
        #1;
    endtask

    task automatic ulr(input logic [2:0] ts, input logic g, input logic c);
        @(posedge clk);
        {ul_req, ul_ts, ul_usf_grant, ul_ctrl_pending} <= {1'b1, ts, g, c};
        @(posedge clk);
        ul_req <= 1'b0;
        #1;
    endtask

    task automatic report_and_stop;
        $display("Comparisons: %0d, mismatches: %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog sized well beyond the fewer than two hundred cycles the sequence needs
    initial begin
        #400000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        {read, write, address, writedata, tch_active, call_disconnect, ec_operation} = '0;
        {dl_frm_valid, dl_frm_word, dl_frm_bad, dl_frm_facch, dl_blk_valid, dl_blk_ctrl} = '0;
        {dl_blk_word, dl_blk_ts, dl_ts_mask, dl_crc_ok, dl_usf_ok, ul_req, ul_ts} = '0;
        {ul_usf_grant, ul_ctrl_pending, tbf_release, dl_release, pdch_release} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Reset values, read-only and unmapped places
        bus(1'b0, ADDR_CAP, 32'h0);
        check(rd, 32'(CAP_RESET));
        bus(1'b1, ADDR_STATUS, 32'h3f);
        status_is(6'h01);
        bus(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0);
        // Command acceptance table
        for (int i = 0; i < 10; i++) begin
            tch_active <= rows[i].tch;
            sim_station_model_inst.send(rows[i].code, rows[i].erased, rows[i].tc, 1'b0,
                                        16'h0, 3'h0);
            #1;
            check(32'({ms_close_ack, ms_open_ack, ss_open_msg}), 32'(rows[i].acks));
            status_is(rows[i].state);
        end
        check(32'(ack_elem), 32'(ACK_ELEM_TYPE_C));
        // Erased-frame loop: good, bad and signalling frames
        sim_station_model_inst.send(CMD_CLOSE_MS, 1'b1, 1'b0, 1'b0, 16'h0, 3'h0);
        frame(16'h1234, 1'b0, 1'b0);
        check(32'({ul_frm_valid, ul_frm_word, frm_to_codec}), 32'h22468);
        frame(16'h5a5a, 1'b1, 1'b0);
        check(32'({ul_frm_valid, ul_frm_word}), 32'h10000);
        frame(16'h0f0f, 1'b0, 1'b1);
        check(32'({ul_frm_valid, facch_fwd}), 32'h1);
        // Disconnect opens the loop with no acknowledgement
        release_pulse(0);
        repeat (3) begin
            #1 check(32'(ms_open_ack), 32'h0);
            @(posedge clk);
        end
        status_is(6'h01);
        frame(16'h2222, 1'b0, 1'b0);
        check(32'({ul_frm_valid, frm_to_codec}), 32'h1);
        // Loop-back with slot mapping from offset 3 over active slots 2 and 3
        bus(1'b1, ADDR_CAP, 32'h7);
        bus(1'b0, ADDR_CAP, 32'h0);
        check(rd, 32'h7);
        dl_ts_mask <= 8'h0c;
        sim_station_model_inst.send(CMD_TEST_MODE, 1'b0, 1'b0, 1'b1, 16'h10, 3'h3);
        status_is(6'h20);
        blk(16'haaaa, 3'h3, 1'b0, 1'b0, 1'b1);
        check(32'({llc_valid, ctrl_valid}), 32'h0);
        blk(16'h5555, 3'h2, 1'b0, 1'b1, 1'b1);
        blk(16'hc3c3, 3'h2, 1'b1, 1'b1, 1'b1);
        check(32'({ctrl_valid, ctrl_word}), 32'h1c3c3);
        for (int s = 0; s < 3; s++) begin
            ulr(3'(s), 1'b1, 1'b0);
            check(32'({ul_blk_valid, ul_blk_word, ul_cv, ul_blk_ts}),
                  32'({1'b1, (s == 0) ? 16'haaaa : 16'h5555, CV_LOOPBACK, 3'(s)}));
        end
        ulr(3'h0, 1'b1, 1'b1);
        check(32'(ul_blk_valid), 32'h0);
        release_pulse(1);
        status_is(6'h01);
        sim_station_model_inst.test_done();
        // Pseudorandom mode with two PDUs, grant and extended coverage
        sim_station_model_inst.send(CMD_TEST_MODE, 1'b0, 1'b0, 1'b0, 16'h2, 3'h0);
        status_is(6'h10);
        blk(16'h1111, 3'h0, 1'b0, 1'b1, 1'b1);
        check(32'(llc_valid), 32'h0);
        ulr(3'h0, 1'b0, 1'b0);
        check(32'(ul_blk_valid), 32'h0);
        ec_operation <= 1'b1;
        ulr(3'h0, 1'b0, 1'b0);
        check(32'({ul_blk_valid, ul_cv}), 32'h11);
        ec_operation <= 1'b0;
        ulr(3'h0, 1'b1, 1'b0);
        check(32'({ul_blk_valid, ul_cv}), 32'h10);
        status_is(6'h01);
        sim_station_model_inst.test_done();
        // Normal operation passes data blocks to the link layer again
        blk(16'h7e7e, 3'h0, 1'b0, 1'b1, 1'b1);
        check(32'({llc_valid, llc_word}), 32'h17e7e);
        report_and_stop();
    end
endmodule
